// File: hdl/aswc_map.vh
/*
  task-file offsets, opcodes, status and error bit positions and reset
  values for the sector-write command handler.
  assumes: included by bare name from hdl/; definitions only.
*/
`ifndef ASWC_MAP_VH
`define ASWC_MAP_VH

// ----------------
// task-file register offsets (host address lines 2..0)
// ----------------
`define ASWC_OFF_DATA        3'h0
`define ASWC_OFF_FEATURE     3'h1
`define ASWC_OFF_COUNT       3'h2
`define ASWC_OFF_SECNUM      3'h3
`define ASWC_OFF_CYL_LO      3'h4
`define ASWC_OFF_CYL_HI      3'h5
`define ASWC_OFF_DRV_HEAD    3'h6
`define ASWC_OFF_CMD         3'h7

// ----------------
// command opcodes and error-posting classes
// ----------------
`define ASWC_OP_WRITE        8'h30
`define ASWC_OP_WRITE_NR     8'h31
`define ASWC_OP_WRITE_NOERS  8'h38
`define ASWC_OP_WRITE_VFY    8'h3C
`define ASWC_OP_READ         8'h20
`define ASWC_OP_READ_NR      8'h21
`define ASWC_OP_RDVFY        8'h40
`define ASWC_OP_RDVFY_NR     8'h41
`define ASWC_CLS_WRITE       2'h0
`define ASWC_CLS_READ        2'h1
`define ASWC_CLS_OTHER       2'h2

// ----------------
// status bit positions and error register masks
// ----------------
`define ASWC_ST_BSY          7
`define ASWC_ST_RDY          6
`define ASWC_ST_DWF          5
`define ASWC_ST_DSC          4
`define ASWC_ST_DRQ          3
`define ASWC_ST_CORR         2
`define ASWC_ST_ERR          0
`define ASWC_ER_BBK          8'h80
`define ASWC_ER_UNC          8'h40
`define ASWC_ER_IDNF         8'h10
`define ASWC_ER_ABRT         8'h04
`define ASWC_ER_AMNF         8'h01

// ----------------
// field positions and reset values
// ----------------
`define ASWC_DH_LBA          6
`define ASWC_RST_BYTE        8'h00
`define ASWC_RST_WORD        16'h0000
`define ASWC_RST_COUNT       8'h01
`define ASWC_RST_SECNUM      8'h01
`define ASWC_RST_DH          8'hA0
`define ASWC_CNT_FULL        9'h100

`endif

// File: hdl/aswc_sync.v
/*
  two-flop synchroniser for a bundle of host pins.
  assumes: pins are quasi-static relative to mclk; the first stage is read
  by the second stage only.
*/
`timescale 1ns/1ps

module aswc_sync #(
  parameter W = 1                // bundle width
) (
  // clock and reset
  input  wire         mclk,
  input  wire         rst_n,
  // pins in, synchronised out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;            // first stage, feeds q only

  // ----------------
  // two stages, reset to all ones so strobes start inactive
  // ----------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b1}};
      q      <= {W{1'b1}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // aswc_sync

// File: hdl/aswc_write_handler.v
/*
  sector-write command handler: task file, BSY/DRQ/interrupt handshake,
  sector data streaming to the media engine, address advance, error posting.
  assumes: host pins are asynchronous and held stable several mclk cycles
  around each strobe (PIO cycles are far slower than mclk); the media engine
  runs on mclk and answers each request with one done pulse.
*/
// What this block does
// RL1: accept 30H/31H, write 1 to 256 sectors
// RL2: count zero means 256 sectors
// RL3: start at addressed sector, advance each sector
// RL4: address from drive/head, cylinder, sector registers
// RL5: on accept set BSY, then DRQ, clear BSY
// RL6: no interrupt before the first sector
// RL7: host sends data only after BSY clears
// RL8: full buffer sets BSY, clears DRQ
// RL9: next buffer ready: clear BSY, DRQ, interrupt
// RL10: last sector: hold BSY until done, interrupt
// RL11: on error stop, keep failing sector address
// RL12: host may read address and error after failure
// RL13: opcode 38H runs as plain write
// RL14: opcode 3CH verifies each sector after writing
// RL15: writes post BBK, IDNF, ABRT, AMNF only
// RL16: reads add UNC; non-media post ABRT only
// RL17: host reissues media commands ending in error
// RL18: LBA bit clear means cylinder/head/sector addressing
`timescale 1ns/1ps
`include "aswc_map.vh"

module aswc_write_handler #(
  parameter WORDS_PER_SECTOR = 256,   // 16-bit words per sector buffer
  parameter SECTORS_PER_TRK  = 63,    // chs geometry: sectors per track
  parameter HEADS            = 16     // chs geometry: heads
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // host task-file pins
  input  wire        host_cs_n,
  input  wire [2:0]  host_addr,
  input  wire        host_wr_n,
  input  wire        host_rd_n,
  input  wire [15:0] host_dd_in,
  output reg  [15:0] host_dd_out_q,
  output reg         host_dd_oe_q,
  output reg         host_intrq_q,
  // device state
  input  wire        dev_ready,
  // media engine
  output reg         med_req_q,
  output reg         med_verify_q,
  output reg         med_lba_mode_q,
  output reg  [27:0] med_addr_q,
  output reg  [15:0] med_wdata_q,
  output reg         med_wvalid_q,
  input  wire        med_done,
  input  wire        med_fail,
  input  wire        med_fault,
  input  wire [7:0]  med_err_bits
);

  // ----------------
  // constants
  // ----------------
  localparam [2:0] ST_IDLE   = 3'h0;  // waiting for a command
  localparam [2:0] ST_ACCEPT = 3'h1;  // BSY after command accept
  localparam [2:0] ST_XFER   = 3'h2;  // DRQ, host fills the buffer
  localparam [2:0] ST_MEDIA  = 3'h3;  // BSY, media takes the sector
  localparam [8:0] WORD_LAST = WORDS_PER_SECTOR[8:0] - 9'h001;  // cut to the counter width
  localparam [7:0] SPT       = SECTORS_PER_TRK[7:0];
  localparam [3:0] HEAD_LAST = HEADS[3:0] - 4'h1;

  // ----------------
  // pin synchronisation
  // ----------------
  wire [21:0] pin_s;                  // synchronised pin bundle
  wire        cs_n_s;                 // chip select
  wire [2:0]  addr_s;                 // register offset
  wire        wr_n_s;                 // write strobe
  wire        rd_n_s;                 // read strobe
  wire [15:0] dd_s;                   // write data

  aswc_sync #(
    .W (22)
  ) u_pin_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({host_cs_n, host_addr, host_wr_n, host_rd_n, host_dd_in}),
    .q     (pin_s)
  );

  assign cs_n_s = pin_s[21];
  assign addr_s = pin_s[20:18];
  assign wr_n_s = pin_s[17];
  assign rd_n_s = pin_s[16];
  assign dd_s   = pin_s[15:0];

  // ----------------
  // state
  // ----------------
  reg  [2:0]  state_q;                // handshake state
  reg         wr_act_q;               // write strobe active last cycle
  reg         rd_act_q;               // read strobe active last cycle
  reg  [2:0]  lat_addr_q;             // offset latched during write strobe
  reg  [15:0] lat_data_q;             // data latched during write strobe
  reg  [7:0]  tf_count_q;             // transfer_sector_count
  reg  [7:0]  tf_secnum_q;            // start_sector_number
  reg  [7:0]  tf_cyl_lo_q;            // cylinder_low_byte
  reg  [7:0]  tf_cyl_hi_q;            // cylinder_high_byte
  reg  [7:0]  tf_dh_q;                // drive_head_select
  reg  [7:0]  err_q;                  // error register
  reg         st_err_q;               // status ERR
  reg         st_dwf_q;               // status write fault
  reg  [8:0]  remain_q;               // sectors still to write
  reg  [8:0]  word_q;                 // words taken in this sector
  reg  [1:0]  cls_q;                  // class of the running command

  wire        wr_act  = ~wr_n_s & ~cs_n_s;
  wire        rd_act  = ~rd_n_s & ~cs_n_s;
  wire        wr_done = wr_act_q & ~wr_act;   // end of a host write
  wire        rd_start = rd_act & ~rd_act_q;  // start of a host read
  wire        busy    = (state_q == ST_ACCEPT) || (state_q == ST_MEDIA);
  wire        drq     = (state_q == ST_XFER);
  wire [27:0] tf_addr = {tf_dh_q[3:0], tf_cyl_hi_q, tf_cyl_lo_q, tf_secnum_q};
  wire        lba_on  = tf_dh_q[`ASWC_DH_LBA];
  wire [7:0]  status  = {busy, dev_ready, st_dwf_q, 1'b1, drq, 1'b0, 1'b0, st_err_q};

  // ----------------
  // functions
  // ----------------
  // opcode to error-posting class
  function [1:0] cmd_class;
    input [7:0] op;
    begin
      case (op)
        `ASWC_OP_WRITE, `ASWC_OP_WRITE_NR,
        `ASWC_OP_WRITE_NOERS, `ASWC_OP_WRITE_VFY: cmd_class = `ASWC_CLS_WRITE;
        `ASWC_OP_READ, `ASWC_OP_READ_NR,
        `ASWC_OP_RDVFY, `ASWC_OP_RDVFY_NR:        cmd_class = `ASWC_CLS_READ;
        default:                                  cmd_class = `ASWC_CLS_OTHER;
      endcase
    end
  endfunction

  // error bits a class may post; CORR is never set since writes lack it
  function [7:0] err_mask;
    input [1:0] cls;
    begin
      case (cls)
        `ASWC_CLS_WRITE: err_mask = `ASWC_ER_BBK | `ASWC_ER_IDNF | `ASWC_ER_ABRT | `ASWC_ER_AMNF; // see RL15
        `ASWC_CLS_READ:  err_mask = `ASWC_ER_BBK | `ASWC_ER_UNC | `ASWC_ER_IDNF |
                                    `ASWC_ER_ABRT | `ASWC_ER_AMNF; // see RL16
        default:         err_mask = `ASWC_ER_ABRT; // see RL16
      endcase
    end
  endfunction

  // next sector address, lba or cylinder/head/sector
  function [27:0] next_addr;
    input [27:0] a;
    input        lba;
    reg   [7:0]  s;
    reg   [3:0]  h;
    reg   [15:0] c;
    begin
      s = a[7:0];
      c = a[23:8];
      h = a[27:24];
      if (lba) begin
        next_addr = a + 28'h000_0001;   // see RL3
      end else begin
        // chs: sectors count from one, wrap into head then cylinder
        if (s >= SPT) begin            // see RL18
          s = 8'h01;
          if (h >= HEAD_LAST) begin
            h = 4'h0;
            c = c + 16'h0001;
          end else begin
            h = h + 4'h1;
          end
        end else begin
          s = s + 8'h01;
        end
        next_addr = {h, c, s};
      end
    end
  endfunction

  // ----------------
  // host strobe tracking and write latch
  // ----------------
  // address and data are latched while the strobe is low, so the commit on
  // its release does not depend on pins that may already be changing
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_q   <= 1'b0;
      rd_act_q   <= 1'b0;
      lat_addr_q <= 3'h0;
      lat_data_q <= `ASWC_RST_WORD;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        lat_addr_q <= addr_s;
        lat_data_q <= dd_s;
      end
    end
  end

  // ----------------
  // host read path
  // ----------------
  // data register reads return zero: this block only takes write data
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_dd_out_q <= `ASWC_RST_WORD;
      host_dd_oe_q  <= 1'b0;
    end else begin
      host_dd_oe_q <= rd_act;
      case (addr_s)
        `ASWC_OFF_FEATURE:  host_dd_out_q <= {8'h00, err_q};       // see RL12
        `ASWC_OFF_COUNT:    host_dd_out_q <= {8'h00, tf_count_q};
        `ASWC_OFF_SECNUM:   host_dd_out_q <= {8'h00, tf_secnum_q};
        `ASWC_OFF_CYL_LO:   host_dd_out_q <= {8'h00, tf_cyl_lo_q};
        `ASWC_OFF_CYL_HI:   host_dd_out_q <= {8'h00, tf_cyl_hi_q};
        `ASWC_OFF_DRV_HEAD: host_dd_out_q <= {8'h00, tf_dh_q};
        `ASWC_OFF_CMD:      host_dd_out_q <= {8'h00, status};
        default:            host_dd_out_q <= `ASWC_RST_WORD;
      endcase
    end
  end

  // ----------------
  // command handshake and task file
  // ----------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q        <= ST_IDLE;
      tf_count_q     <= `ASWC_RST_COUNT;
      tf_secnum_q    <= `ASWC_RST_SECNUM;
      tf_cyl_lo_q    <= `ASWC_RST_BYTE;
      tf_cyl_hi_q    <= `ASWC_RST_BYTE;
      tf_dh_q        <= `ASWC_RST_DH;
      err_q          <= `ASWC_RST_BYTE;
      st_err_q       <= 1'b0;
      st_dwf_q       <= 1'b0;
      remain_q       <= 9'h000;
      word_q         <= 9'h000;
      cls_q          <= `ASWC_CLS_OTHER;
      host_intrq_q   <= 1'b0;
      med_req_q      <= 1'b0;
      med_verify_q   <= 1'b0;
      med_lba_mode_q <= 1'b0;
      med_addr_q     <= 28'h000_0000;
      med_wdata_q    <= `ASWC_RST_WORD;
      med_wvalid_q   <= 1'b0;
    end else begin
      med_req_q    <= 1'b0;
      med_wvalid_q <= 1'b0;
      // status read clears the interrupt; a same-cycle set below wins
      if (rd_start && (addr_s == `ASWC_OFF_CMD)) begin
        host_intrq_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          // task-file writes only while not busy; feature is accepted and ignored
          if (wr_done) begin
            case (lat_addr_q)
              `ASWC_OFF_COUNT:    tf_count_q  <= lat_data_q[7:0];
              `ASWC_OFF_SECNUM:   tf_secnum_q <= lat_data_q[7:0];
              `ASWC_OFF_CYL_LO:   tf_cyl_lo_q <= lat_data_q[7:0];
              `ASWC_OFF_CYL_HI:   tf_cyl_hi_q <= lat_data_q[7:0];
              `ASWC_OFF_DRV_HEAD: tf_dh_q     <= lat_data_q[7:0];
              `ASWC_OFF_CMD: begin
                cls_q    <= cmd_class(lat_data_q[7:0]);
                st_dwf_q <= 1'b0;
                if (cmd_class(lat_data_q[7:0]) == `ASWC_CLS_WRITE) begin
                  // 30H/31H/38H share one path, 3CH adds verify
                  err_q        <= `ASWC_RST_BYTE;
                  st_err_q     <= 1'b0;
                  med_verify_q <= (lat_data_q[7:0] == `ASWC_OP_WRITE_VFY); // see RL13, RL14
                  remain_q     <= (tf_count_q == 8'h00) ? `ASWC_CNT_FULL
                                                        : {1'b0, tf_count_q}; // see RL1, RL2
                  word_q       <= 9'h000;
                  state_q      <= ST_ACCEPT;                                  // see RL5
                end else begin
                  // commands not executed here end at once with abort
                  err_q        <= `ASWC_ER_ABRT & err_mask(cmd_class(lat_data_q[7:0])); // see RL16
                  st_err_q     <= 1'b1;
                  host_intrq_q <= 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
        ST_ACCEPT: begin
          // BSY for one cycle, then DRQ with no interrupt for sector one
          state_q <= ST_XFER;                                          // see RL5, RL6
        end
        ST_XFER: begin
          // data register writes stream out; host waits for BSY low first
          if (wr_done && (lat_addr_q == `ASWC_OFF_DATA)) begin        // see RL7
            med_wdata_q  <= lat_data_q;
            med_wvalid_q <= 1'b1;
            if (word_q == WORD_LAST) begin
              word_q         <= 9'h000;
              med_req_q      <= 1'b1;
              med_addr_q     <= tf_addr;                               // see RL4
              med_lba_mode_q <= lba_on;                                // see RL18
              state_q        <= ST_MEDIA;                              // see RL8
            end else begin
              word_q <= word_q + 9'h001;
            end
          end
        end
        ST_MEDIA: begin
          // BSY held until the media engine answers for this sector
          if (med_done) begin
            if (med_fail || med_fault) begin
              // stop here; task file still names the failing sector
              err_q        <= med_err_bits & err_mask(cls_q);          // see RL11, RL15
              st_dwf_q     <= med_fault;
              st_err_q     <= 1'b1;
              tf_count_q   <= remain_q[7:0];
              host_intrq_q <= 1'b1;
              state_q      <= ST_IDLE;
            end else begin
              {tf_dh_q[3:0], tf_cyl_hi_q, tf_cyl_lo_q, tf_secnum_q}
                <= next_addr(tf_addr, lba_on);                         // see RL3
              remain_q     <= remain_q - 9'h001;
              tf_count_q   <= remain_q[7:0] - 8'h01;
              host_intrq_q <= 1'b1;
              if (remain_q == 9'h001) begin
                state_q <= ST_IDLE;                                    // see RL10
              end else begin
                state_q <= ST_XFER;                                    // see RL9
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // aswc_write_handler

// File: verif/aswc_props_properties.sv
/*
  checker on the sector-write handler's ports: media handshake, address, interrupt, read drive.
  assumes: bound to aswc_write_handler; one clock, async low reset.
*/
`timescale 1ns/1ps

module aswc_props (
  // clock and reset
  input wire        mclk,
  input wire        rst_n,
  // host pins
  input wire        host_cs_n,
  input wire [2:0]  host_addr,
  input wire        host_wr_n,
  input wire        host_rd_n,
  input wire        host_dd_oe_q,
  input wire        host_intrq_q,
  // media side
  input wire        med_req_q,
  input wire        med_verify_q,
  input wire        med_lba_mode_q,
  input wire [27:0] med_addr_q,
  input wire        med_wvalid_q,
  input wire        med_done,
  input wire        med_fail,
  input wire        med_fault
);
  // ----------------
  // helpers
  // ----------------
  reg        pend_q;  // sector with the media; a done without it is ignored
  reg        nv_q;    // the next request must carry na_q
  reg [27:0] na_q;    // block address after a clean sector

  // a command write brings its own start address, so it drops the expectation
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pend_q, nv_q, na_q} <= 30'h0;
    end else begin
      pend_q <= med_req_q | (pend_q & ~med_done);
      if (!host_wr_n && !host_cs_n && host_addr == 3'h7) begin
        nv_q <= 1'b0;
      end else if (pend_q && med_done) begin
        nv_q <= med_lba_mode_q && !med_fail && !med_fault;
        na_q <= med_addr_q + 28'h000_0001;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------
  // assertions
  // ----------------
  a_req_single_pulse: assert property (med_req_q |=> !med_req_q)
    else $error("media request longer than one cycle");
  a_no_data_busy: assert property (pend_q |-> !med_wvalid_q)
    else $error("data word passed while busy");
  a_irq_after_done: assert property (pend_q && med_done |=> host_intrq_q)
    else $error("no interrupt after sector done");
  a_no_irq_busy: assert property (pend_q && !med_done |=> !$rose(host_intrq_q))
    else $error("interrupt while sector in flight");
  a_addr_held_busy: assert property (pend_q && !med_done |=> $stable(med_addr_q))
    else $error("address moved while busy");
  a_addr_next_lba: assert property (med_req_q && nv_q |-> med_addr_q == na_q)
    else $error("block address did not advance by one");
  a_fail_addr_kept: assert property (pend_q && med_done && (med_fail || med_fault) |=> $stable(med_addr_q))
    else $error("failing sector address lost");
  a_mode_stable_busy: assert property (pend_q && !med_done |=> $stable(med_verify_q) && $stable(med_lba_mode_q))
    else $error("verify or mode changed mid sector");
  a_read_drives_bus: assert property ((!host_rd_n && !host_cs_n)[*4] |-> host_dd_oe_q)
    else $error("read not driven");
  a_bus_released: assert property ((host_rd_n || host_cs_n)[*4] |-> !host_dd_oe_q)
    else $error("bus driven outside read");

  c_verify_req: cover property (med_req_q && med_verify_q);
  c_chs_req: cover property (med_req_q && !med_lba_mode_q);
  c_fail_done: cover property (pend_q && med_done && med_fail);
endmodule // aswc_props

bind aswc_write_handler aswc_props u_props (.mclk, .rst_n, .host_cs_n, .host_rd_n, .host_dd_oe_q, .host_intrq_q,
  .host_addr, .host_wr_n, .med_req_q, .med_verify_q, .med_lba_mode_q, .med_addr_q, .med_wvalid_q,
  .med_done, .med_fail, .med_fault);

// File: verif/aswc_media_model.sv
/*
  media engine stand-in: answers each sector request with one done pulse.
  assumes: runs on the handler's mclk; the bench sets delay and fault injection.
*/
`timescale 1ns/1ps

module aswc_media_model (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // handler side
  input  wire        med_req_q,
  input  wire [27:0] med_addr_q,
  output reg         med_done,
  output reg         med_fail,
  output reg         med_fault,
  output reg  [7:0]  med_err_bits,
  // bench controls
  input  wire [7:0]  dly,
  input  wire        fail_en,
  input  wire [27:0] fail_addr,
  input  wire        fault_in,
  input  wire [7:0]  err_in
);
  reg [7:0] cnt_q;   // cycles left before done
  reg       busy_q;  // a sector is in flight
  reg       hit_q;   // this sector is the one to fail

  // qualifiers toggle outside done so stale values are never trusted
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {cnt_q, busy_q, hit_q} <= 10'h000;
      {med_done, med_fail, med_fault, med_err_bits} <= 11'h000;
    end else begin
      med_done     <= 1'b0;
      med_fail     <= ~med_fail;
      med_fault    <= ~med_fault;
      med_err_bits <= ~med_err_bits;
      if (med_req_q) begin
        busy_q <= 1'b1;
        cnt_q  <= dly;
        hit_q  <= fail_en && (med_addr_q == fail_addr);
      end else if (busy_q && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (busy_q) begin
        // answer: done with its qualifiers for one cycle
        busy_q       <= 1'b0;
        med_done     <= 1'b1;
        med_fail     <= hit_q;
        med_fault    <= hit_q & fault_in;
        med_err_bits <= err_in;
      end
    end
  end
endmodule // aswc_media_model

// File: verif/tb_top.sv
/*
  bench for the sector-write handler: pin tasks, media stand-in, monitor, scenarios.
  assumes: aswc_map.vh on the include path; 200 MHz mclk.
*/
`timescale 1ns/1ps
`include "aswc_map.vh"
`define CHK(g, e) begin checked = checked + 1; if ((g) !== (e)) begin fail_count = fail_count + 1; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end

module tb_top;
  localparam WPS = 4;   // short sectors keep the 256-sector run brief
  localparam SPT = 63;  // geometry as the design defaults
  localparam HDS = 16;
  reg         mclk, rst_n, host_cs_n, host_wr_n, host_rd_n, dev_ready;
  reg  [2:0]  host_addr;
  reg  [15:0] host_dd_in;
  wire [15:0] host_dd_out_q, med_wdata_q;
  wire        host_dd_oe_q, host_intrq_q, med_req_q, med_verify_q, med_lba_mode_q, med_wvalid_q;
  wire        med_done, med_fail, med_fault;
  wire [27:0] med_addr_q;
  wire [7:0]  med_err_bits;
  reg  [7:0]  m_dly, m_err;           // media delay and error bits
  reg         m_fen, m_flt;           // fail enable, fault flag
  reg  [27:0] m_faddr;                // sector that fails
  reg  [27:0] exp_addr, req_addr;     // next expected / last requested address
  reg         exp_lba, exp_vfy;
  reg  [15:0] exp_word, wr_word;      // data seen / data sent
  integer     fail_count, checked, i;

  aswc_write_handler #(.WORDS_PER_SECTOR(WPS), .SECTORS_PER_TRK(SPT), .HEADS(HDS)) uut (.mclk, .rst_n,
    .host_cs_n, .host_addr, .host_wr_n, .host_rd_n, .host_dd_in, .host_dd_out_q, .host_dd_oe_q, .host_intrq_q,
    .dev_ready, .med_req_q, .med_verify_q, .med_lba_mode_q, .med_addr_q, .med_wdata_q, .med_wvalid_q,
    .med_done, .med_fail, .med_fault, .med_err_bits);
  aswc_media_model u_med (.mclk, .rst_n, .med_req_q, .med_addr_q, .med_done, .med_fail, .med_fault,
    .med_err_bits, .dly(m_dly), .fail_en(m_fen), .fail_addr(m_faddr), .fault_in(m_flt), .err_in(m_err));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // next sector: block number plus one, or sector/head/cylinder roll
  function [27:0] nxt(input [27:0] a, input l);
    begin
      nxt = a + 28'h000_0001;
      if (!l) begin
        nxt = {a[27:8], a[7:0] + 8'h01};
        if (a[7:0] == SPT) nxt = (a[27:24] == HDS - 1) ? {4'h0, a[23:8] + 16'h0001, 8'h01} : {a[27:24] + 4'h1, a[23:8], 8'h01};
      end
    end
  endfunction

  // monitor: every data word and every sector request
  always @(posedge mclk) begin
    if (med_wvalid_q) begin
      `CHK(med_wdata_q, exp_word)
      exp_word = exp_word + 16'h0001;
    end
    if (med_req_q) begin
      `CHK(med_addr_q, exp_addr)
      `CHK(med_lba_mode_q, exp_lba)
      `CHK(med_verify_q, exp_vfy)
      req_addr = exp_addr;
      exp_addr = nxt(exp_addr, exp_lba);
    end
  end

  // host write: strobe held 4 cycles, released 5
  task hwr(input [2:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      #1 {host_addr, host_dd_in, host_cs_n, host_wr_n} = {a, d, 2'b00};
      repeat (4) @(posedge mclk);
      #1 {host_cs_n, host_wr_n} = 2'b11;
      repeat (5) @(posedge mclk);
    end
  endtask

  // host read of a task-file byte, compared at once
  task hrd(input [2:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      #1 {host_addr, host_cs_n, host_rd_n} = {a, 2'b00};
      repeat (4) @(posedge mclk);
      #1;
      `CHK(host_dd_oe_q, 1'b1)
      `CHK(host_dd_out_q, {8'h00, e})
      {host_cs_n, host_rd_n} = 2'b11;
      repeat (5) @(posedge mclk);
    end
  endtask

  task wait_irq;
    begin
      i = 0;
      while (host_intrq_q !== 1'b1 && i < 4000) begin
        @(posedge mclk);
        i = i + 1;
      end
      #1 `CHK(host_intrq_q, 1'b1)
    end
  endtask

  // one full command: set up, issue, stream, judge; fs is the failing sector
  task run_cmd(input [7:0] op, input [7:0] cnt, input [27:0] a, input l, input integer fs);
    integer n, s, w;
    begin
      n = (cnt == 8'h00) ? 256 : cnt;
      {exp_addr, exp_lba, exp_vfy} = {a, l, op == `ASWC_OP_WRITE_VFY};
      hwr(3'h2, {8'h00, cnt});
      hwr(3'h3, {8'h00, a[7:0]});
      hwr(3'h4, {8'h00, a[15:8]});
      hwr(3'h5, {8'h00, a[23:16]});
      hwr(3'h6, {8'h00, 1'b1, l, 2'b10, a[27:24]});
      hwr(3'h7, {8'h00, op});
      `CHK(host_intrq_q, 1'b0)
      hrd(3'h7, 8'h58);
      for (s = 1; s <= n; s = s + 1) begin
        for (w = 0; w < WPS; w = w + 1) begin
          hwr(3'h0, wr_word);
          wr_word = wr_word + 16'h0001;
        end
        if (m_dly > 8'h20) hrd(3'h7, 8'hD0);
        wait_irq;
        if (s == fs) begin
          hrd(3'h7, m_flt ? 8'h71 : 8'h51);
          hrd(3'h1, m_err & 8'h95);
          hrd(3'h2, 8'(n - s + 1));
          hrd(3'h3, req_addr[7:0]);
          hrd(3'h4, req_addr[15:8]);
          s = n + 1;
        end else hrd(3'h7, (s == n) ? 8'h50 : 8'h58);
      end
      if (fs == 0) begin
        hrd(3'h2, 8'h00);
        hrd(3'h3, exp_addr[7:0]);
        hrd(3'h4, exp_addr[15:8]);
        hrd(3'h6, {1'b1, l, 2'b10, exp_addr[27:24]});
      end
    end
  endtask

  task t_reset;
    begin
      hrd(3'h2, 8'h01);
      hrd(3'h6, 8'hA0);
      hrd(3'h7, 8'h50);
      #1 dev_ready = 1'b0;
      hrd(3'h7, 8'h10);
      #1 dev_ready = 1'b1;
    end
  endtask

  task t_ops;
    begin
      run_cmd(`ASWC_OP_WRITE, 8'h01, 28'h000_0010, 1'b1, 0);
      run_cmd(`ASWC_OP_WRITE_NR, 8'h02, 28'hFFF_FFFF, 1'b1, 0);
      run_cmd(`ASWC_OP_WRITE_NOERS, 8'h02, 28'h000_0020, 1'b1, 0);
      run_cmd(`ASWC_OP_WRITE_VFY, 8'h02, 28'h000_0030, 1'b1, 0);
    end
  endtask

  task t_fail;
    begin
      {m_fen, m_flt, m_err, m_faddr} = {2'b10, 8'hFF, 28'h000_0101};
      run_cmd(`ASWC_OP_WRITE_NR, 8'h03, 28'h000_0100, 1'b1, 2);
      {m_flt, m_err, m_faddr} = {1'b1, 8'h5B, 28'h000_0202};
      run_cmd(`ASWC_OP_WRITE_VFY, 8'h04, 28'h000_0200, 1'b1, 3);
      m_fen = 1'b0;
      run_cmd(`ASWC_OP_WRITE, 8'h03, 28'h000_0100, 1'b1, 0);
    end
  endtask

  task t_abort;
    reg [7:0] ops [0:3];
    integer k;
    begin
      {ops[0], ops[1], ops[2], ops[3]} = {`ASWC_OP_READ, `ASWC_OP_RDVFY, 8'hEC, 8'hC5};
      for (k = 0; k < 4; k = k + 1) begin
        hwr(3'h7, {8'h00, ops[k]});
        wait_irq;
        hrd(3'h7, 8'h51);
        hrd(3'h1, `ASWC_ER_ABRT);
      end
    end
  endtask

  task end_sim;
    begin
      if (fail_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    {fail_count, checked} = 64'h0;
    {rst_n, host_cs_n, host_wr_n, host_rd_n, dev_ready, host_addr, host_dd_in} = {5'b01111, 3'h0, 16'h0000};
    {m_dly, m_err, m_fen, m_flt, m_faddr} = {8'h28, 38'h0};
    {exp_addr, req_addr, exp_lba, exp_vfy, exp_word, wr_word} = 90'h0;
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_reset;
    t_ops;
    run_cmd(`ASWC_OP_WRITE, 8'h03, {4'hF, 16'h0105, 8'h3E}, 1'b0, 0);
    t_fail;
    t_abort;
    m_dly = 8'h00;
    run_cmd(`ASWC_OP_WRITE, 8'h00, 28'h123_4500, 1'b1, 0);
    end_sim;
  end

  // watchdog: the full run needs well under 60000 cycles
  initial begin
    #300000;
    fail_count = fail_count + 1;
    end_sim;
  end
endmodule // tb_top
